// ===== src/uax_aux.sv
/*
 * Auxiliary modes of one channel of a serial channel pair: special character detect,
 * infrared encode/decode, loopback routing, sleep with auto wake-up,
 * plus a small FIFO in front of the receive data path.
 * Assumes the core datapath supplies a 16x baud tick and bit streams,
 * and that all inputs are synchronous to sys_clk_i.
 */
// Summary of operation
// - With special detect on, compare each received char; still store it
// - A match sets the special-character status flag
// - Compare only the low 5, 6, 7 or 8 bits per word length
// - Register bit 0 lines up with the received character LSB
// - Infrared encoder sends a 3/16-bit high pulse per zero bit
// - Infrared encoder and decoder enabled by modem control bit 6
// - In infrared mode the transmit pin rests low when idle
// - In infrared mode the receive input idles low from reset
// - Decoder gives a low recovered bit for each sensed light pulse
// - Modem control bit 2 inverts the infrared receive polarity
// - Sleep only if no interrupts, both enabled, no modem change, rx high
// - Sleep stops the oscillator so its output pin shows no clock
// - Wake on rx start edge, transmit write, or modem input change
// - After waking, re-enter sleep once all interrupts are cleared
// - Host reads modem status after modem wake; the read clears changes
// - Keep cycling into sleep until sleep enable bit is cleared
// - Loopback enabled by modem control bit 4; other functions normal
// - Loopback feeds transmit shifter output to receive shifter input
// - Loopback holds tx, rts, dtr pins and ignores modem inputs
// - Automatic hardware flow control is off during loopback
`timescale 1ns/1ps

module uax_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // uax_fifo

module uax_aux
    import uax_pkg::*;
#(
    parameter int CHAR_W = 8,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Channel configuration (this channel)
    input wire logic [7:0] enhanced_feature_reg_i,
    input wire logic [7:0] line_control_reg_i,
    input wire logic [7:0] modem_control_reg_i,
    input wire logic [7:0] interrupt_enable_reg_i,
    input wire logic [7:0] second_pause_char_i,
    // Other channel sleep inputs
    input wire logic other_sleep_en_i,
    input wire logic other_int_pending_i,
    input wire logic other_rx_idle_i,
    input wire logic other_wake_i,
    // Core datapath
    input wire logic baud16_tick_i,
    input wire logic core_tx_bit_i,
    input wire logic core_tx_busy_i,
    input wire logic [CHAR_W-1:0] rx_char_i,
    input wire logic rx_char_valid_i,
    input wire logic int_pending_i,
    input wire logic thr_write_i,
    input wire logic msr_read_i,
    input wire logic special_clear_i,
    input wire logic auto_rtscts_req_i,
    output logic rx_bit_o,
    output logic [CHAR_W-1:0] fifo_data_o,
    output logic fifo_valid_o,
    input wire logic fifo_ready_i,
    output logic rx_char_ready_o,
    output logic special_flag_o,
    output logic [3:0] modem_status_reg_o,
    output logic auto_rtscts_en_o,
    output logic sleep_o,
    // Pins
    input wire logic rx_pin_i,
    input wire logic [3:0] modem_in_i,
    output logic tx_pin_o,
    output logic rts_pin_o,
    output logic dtr_pin_o,
    output logic osc_enable_o
);
    logic ir_en;
    logic loop_en;
    logic [CHAR_W-1:0] cmp_mask;
    logic match;
    logic [3:0] tx_tick_q;
    logic tx_pulse_q;
    logic [3:0] modem_src;
    logic [3:0] modem_prev_q;
    logic [3:0] delta_q;
    logic rx_src;
    logic rx_prev_q;
    logic wake;
    logic may_sleep;
    uax_pwr_t pwr_q;
    logic [CHAR_W-1:0] fifo_dout;
    logic fifo_vout;
    logic fifo_rdy;

    assign ir_en = modem_control_reg_i[MCR_IR_BIT];
    assign loop_en = modem_control_reg_i[MCR_LOOP_BIT];

    // Compare mask from word length; bit 0 is the character LSB
    always_comb
    begin
        case (line_control_reg_i[1:0])
            WLEN_5: cmp_mask = CHAR_W'(8'h1f);
            WLEN_6: cmp_mask = CHAR_W'(8'h3f);
            WLEN_7: cmp_mask = CHAR_W'(8'h7f);
            default: cmp_mask = CHAR_W'(8'hff);
        endcase
    end
    assign match = ((rx_char_i & cmp_mask) == (second_pause_char_i[CHAR_W-1:0] & cmp_mask));

    // Every received char goes to the FIFO while it has room, matched or not
    uax_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_data_i(rx_char_i),
        .in_valid_i(rx_char_valid_i),
        .in_ready_o(fifo_rdy),
        .out_data_o(fifo_dout),
        .out_valid_o(fifo_vout),
        .out_ready_i(fifo_ready_i)
    );
    assign fifo_data_o = fifo_dout;
    assign fifo_valid_o = fifo_vout;
    assign rx_char_ready_o = fifo_rdy;

    // Special flag: set wins over a simultaneous clear
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            special_flag_o <= 1'b0;
        end
        else if (rx_char_valid_i && fifo_rdy && enhanced_feature_reg_i[EFR_SPECIAL_BIT] && match)
        begin
            special_flag_o <= 1'b1;
        end
        else if (special_clear_i)
        begin
            special_flag_o <= 1'b0;
        end
    end

    // Infrared encoder: 3 of 16 ticks high at the start of each zero bit
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_tick_q <= 4'h0;
            tx_pulse_q <= 1'b0;
        end
        else if (!core_tx_busy_i)
        begin
            tx_tick_q <= 4'h0;
            tx_pulse_q <= 1'b0;
        end
        else if (baud16_tick_i)
        begin
            tx_tick_q <= (tx_tick_q == IR_TICKS_PER_BIT) ? 4'h0 : tx_tick_q + 4'h1;
            tx_pulse_q <= !core_tx_bit_i && (tx_tick_q < IR_PULSE_TICKS);
        end
    end

    // Receive source: pin, decoded infrared, or looped transmit bit
    always_comb
    begin
        if (loop_en)
        begin
            rx_src = core_tx_bit_i;
        end
        else if (ir_en)
        begin
            // Light pulse gives a low; dark gives a high; optional inversion
            rx_src = !(rx_pin_i ^ modem_control_reg_i[MCR_IRINV_BIT]);
        end
        else
        begin
            rx_src = rx_pin_i;
        end
    end

    // Modem status source; looped outputs replace the pins
    assign modem_src = loop_en ? {modem_control_reg_i[MCR_OUT2_BIT],
                                  modem_control_reg_i[MCR_OUT1_BIT],
                                  modem_control_reg_i[MCR_DTR_BIT],
                                  modem_control_reg_i[MCR_RTS_BIT]}
                               : modem_in_i;

    // Change indications; the status read clears, a new change wins
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            modem_prev_q <= MODEM_RESET;
            delta_q <= MODEM_RESET;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            modem_prev_q <= modem_src;
            rx_prev_q <= rx_src;
            delta_q <= (msr_read_i ? 4'h0 : delta_q) | (modem_prev_q ^ modem_src);
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_pin_o <= 1'b1;
            rts_pin_o <= 1'b1;
            dtr_pin_o <= 1'b1;
            rx_bit_o <= 1'b1;
            modem_status_reg_o <= MODEM_RESET;
            auto_rtscts_en_o <= 1'b0;
        end
        else
        begin
            // Loopback parks pins inactive
            if (loop_en)
            begin
                tx_pin_o <= 1'b1;
                rts_pin_o <= 1'b1;
                dtr_pin_o <= 1'b1;
            end
            else
            begin
                tx_pin_o <= ir_en ? tx_pulse_q : core_tx_bit_i;
                rts_pin_o <= !modem_control_reg_i[MCR_RTS_BIT];
                dtr_pin_o <= !modem_control_reg_i[MCR_DTR_BIT];
            end
            rx_bit_o <= rx_src;
            modem_status_reg_o <= delta_q;
            auto_rtscts_en_o <= auto_rtscts_req_i && !loop_en;
        end
    end

    // Sleep control; a new wake source blocks entry
    assign wake = (rx_prev_q && !rx_src) || thr_write_i || (|(modem_prev_q ^ modem_src))
                  || other_wake_i;
    assign may_sleep = !int_pending_i && !other_int_pending_i
                       && interrupt_enable_reg_i[IER_SLEEP_BIT] && other_sleep_en_i
                       && (delta_q == 4'h0) && rx_src && other_rx_idle_i
                       && !core_tx_busy_i;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pwr_q <= PWR_RUN;
        end
        else
        begin
            case (pwr_q)
                PWR_RUN:
                begin
                    if (may_sleep && !wake)
                    begin
                        pwr_q <= PWR_ENTER;
                    end
                end
                PWR_ENTER:
                begin
                    pwr_q <= (may_sleep && !wake) ? PWR_SLEEP : PWR_RUN;
                end
                PWR_SLEEP:
                begin
                    if (wake || !may_sleep)
                    begin
                        pwr_q <= PWR_RUN;
                    end
                end
                default:
                begin
                    pwr_q <= PWR_RUN;
                end
            endcase
        end
    end

    // Oscillator gate; real clock stop is outside this logic
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sleep_o <= 1'b0;
            osc_enable_o <= 1'b1;
        end
        else
        begin
            sleep_o <= (pwr_q == PWR_SLEEP) && !wake;
            osc_enable_o <= !((pwr_q == PWR_SLEEP) && !wake);
        end
    end
endmodule // uax_aux

// ===== src/uax_pkg.sv
/*
 * Package for the serial-port auxiliary modes block: bit positions,
 * word-length codes, reset values and infrared timing constants.
 * Assumes one 100 MHz system clock.
 */
package uax_pkg;
    // Field positions in the channel control registers
    localparam int EFR_SPECIAL_BIT = 5;
    localparam int ISR_SPECIAL_BIT = 4;
    localparam int IER_SLEEP_BIT = 4;
    localparam int MCR_IR_BIT = 6;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MCR_IRINV_BIT = 2;
    localparam int MCR_OUT1_BIT = 2;
    localparam int MCR_OUT2_BIT = 3;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_DTR_BIT = 0;
    // Word length codes
    localparam logic [1:0] WLEN_5 = 2'h0;
    localparam logic [1:0] WLEN_6 = 2'h1;
    localparam logic [1:0] WLEN_7 = 2'h2;
    localparam logic [1:0] WLEN_8 = 2'h3;
    // Infrared pulse is 3/16 of a bit period, counted in 16x ticks
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [3:0] IR_TICKS_PER_BIT = 4'hf;
    // Reset values
    localparam logic [7:0] CHAR_RESET = 8'h00;
    localparam logic [3:0] MODEM_RESET = 4'h0;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_ENTER,
        PWR_SLEEP
    } uax_pwr_t;
endpackage

// ===== verif/test_uax_aux.sv
/*
 * Self-checking bench for uax_aux with the far-side line model.
 * Assumes the checker file binds itself in.
 */
`timescale 1ns/1ps
module test_uax_aux
    import uax_pkg::*;
;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, baud16_tick_i = 1'b1, other_wake_i = 1'b0;
    logic [7:0] enhanced_feature_reg_i = 8'h00, line_control_reg_i = 8'h03;
    logic [7:0] modem_control_reg_i = 8'h00, interrupt_enable_reg_i = 8'h00;
    logic [7:0] second_pause_char_i = 8'h00, rx_char_i = 8'h00, fifo_data_o;
    logic other_sleep_en_i = 1'b0, other_int_pending_i = 1'b0, other_rx_idle_i = 1'b1;
    logic core_tx_bit_i = 1'b1, core_tx_busy_i = 1'b0, rx_char_valid_i = 1'b0;
    logic int_pending_i = 1'b0, thr_write_i = 1'b0, msr_read_i = 1'b0, special_clear_i = 1'b0;
    logic auto_rtscts_req_i = 1'b1, fifo_ready_i = 1'b1, fire = 1'b0, prev;
    logic [3:0] modem_in_i = 4'h0, modem_status_reg_o;
    logic rx_bit_o, fifo_valid_o, rx_char_ready_o, special_flag_o, auto_rtscts_en_o, sleep_o;
    logic tx_pin_o, rts_pin_o, dtr_pin_o, osc_enable_o, rx_pin_i;
    logic [31:0] lf = 32'h11176a3f;
    logic [7:0] exp_q[$];
    int mismatches = 0, n_checks = 0, cyc = 0;

    uax_aux u_dut (.*);
    uax_remote u_rem (.sys_clk_i, .ir_i(modem_control_reg_i[6]), .inv_i(modem_control_reg_i[2]),
        .fire_i(fire), .rx_o(rx_pin_i));

    always #5 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Gap edge at the end keeps valid from being driven twice in one step
    task automatic send(input logic [7:0] c, input logic keep);
        rx_char_i <= c;
        rx_char_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        rx_char_valid_i <= 1'b0;
        if (keep)
            exp_q.push_back(c);
        @(posedge sys_clk_i);
    endtask

    task automatic pulse_msr();
        msr_read_i <= 1'b1;
        @(posedge sys_clk_i);
        msr_read_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask

    task automatic wait_sleep(input logic want);
        for (int n = 0; n < 30 && sleep_o !== want; n++)
            @(posedge sys_clk_i);
        check(8'(sleep_o), 8'(want));
    endtask

    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            final_report();
        end
        if (!rst_i && fifo_valid_o && fifo_ready_i)
            check(fifo_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial
    begin
        logic [7:0] m;
        int k;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        enhanced_feature_reg_i <= 8'h20;
        for (int w = 0; w < 4; w++)
        begin
            lf = lfsr(lf);
            m = 8'hff >> (3 - w);
            line_control_reg_i <= 8'(w);
            second_pause_char_i <= lf[7:0];
            @(posedge sys_clk_i);
            send(lf[7:0] ^ ~m, 1'b1);
            check(8'(special_flag_o), 8'h01);
            special_clear_i <= 1'b1;
            @(posedge sys_clk_i);
            special_clear_i <= 1'b0;
            send(lf[7:0] ^ m ^ (m >> 1), 1'b1);
            check(8'(special_flag_o), 8'h00);
        end
        enhanced_feature_reg_i <= 8'h00;
        send(lf[7:0], 1'b1);
        check(8'(special_flag_o), 8'h00);
        $display("special character test done");
        fifo_ready_i <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            lf = lfsr(lf);
            send(lf[7:0], i < 4);
        end
        check(8'(rx_char_ready_o), 8'h00);
        fifo_ready_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        check(8'(fifo_valid_o), 8'h00);
        check(8'(exp_q.size()), 8'h00);
        $display("fifo test done");
        modem_control_reg_i <= 8'h10;
        repeat (3) @(posedge sys_clk_i);
        check(8'(auto_rtscts_en_o), 8'h00);
        pulse_msr();
        for (int i = 0; i < 16; i++)
        begin
            lf = lfsr(lf);
            core_tx_bit_i <= lf[0];
            modem_in_i <= lf[7:4];
            @(posedge sys_clk_i);
            if (i > 0)
                check(8'(rx_bit_o), 8'(prev));
            prev = lf[0];
            check(8'(tx_pin_o), 8'h01);
        end
        check(8'(modem_status_reg_o), 8'h00);
        modem_control_reg_i <= 8'h1f;
        repeat (4) @(posedge sys_clk_i);
        check(8'(modem_status_reg_o), 8'h0f);
        check(8'({rts_pin_o, dtr_pin_o}), 8'h03);
        pulse_msr();
        check(8'(modem_status_reg_o), 8'h00);
        modem_control_reg_i <= 8'h40;
        core_tx_bit_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        check(8'(auto_rtscts_en_o), 8'h01);
        check(8'(tx_pin_o), 8'h00);
        check(8'(rx_bit_o), 8'h01);
        $display("loopback test done");
        for (int v = 0; v < 2; v++)
        begin
            modem_control_reg_i <= 8'h40 | 8'(v << 2);
            @(posedge sys_clk_i);
            fire <= 1'b1;
            @(posedge sys_clk_i);
            fire <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            check(8'(rx_bit_o), 8'h00);
            repeat (4) @(posedge sys_clk_i);
            check(8'(rx_bit_o), 8'h01);
        end
        modem_control_reg_i <= 8'h40;
        core_tx_busy_i <= 1'b1;
        core_tx_bit_i <= 1'b0;
        k = 0;
        for (int i = 0; i < 40; i++)
        begin
            if (i == 16)
                core_tx_bit_i <= 1'b1;
            if (i == 32)
                core_tx_busy_i <= 1'b0;
            @(posedge sys_clk_i);
            k += (tx_pin_o === 1'b1);
        end
        check(8'(k), 8'(IR_PULSE_TICKS));
        $display("infrared test done");
        modem_control_reg_i <= 8'h03;
        pulse_msr();
        interrupt_enable_reg_i <= 8'h10;
        other_sleep_en_i <= 1'b1;
        wait_sleep(1'b1);
        check(8'(osc_enable_o), 8'h00);
        check(8'({rts_pin_o, dtr_pin_o}), 8'h00);
        thr_write_i <= 1'b1;
        @(posedge sys_clk_i);
        thr_write_i <= 1'b0;
        wait_sleep(1'b0);
        wait_sleep(1'b1);
        modem_in_i <= modem_in_i ^ 4'h1;
        wait_sleep(1'b0);
        int_pending_i <= 1'b1;
        pulse_msr();
        repeat (20) @(posedge sys_clk_i);
        check(8'(sleep_o), 8'h00);
        int_pending_i <= 1'b0;
        wait_sleep(1'b1);
        interrupt_enable_reg_i <= 8'h00;
        wait_sleep(1'b0);
        $display("sleep test done");
        final_report();
    end
endmodule // test_uax_aux

// ===== verif/uax_aux_checker.sv
/*
 * Port-level assertions for uax_aux.
 * Sees only the top ports; bound to every uax_aux instance below.
 */
`timescale 1ns/1ps
module uax_aux_checker
    import uax_pkg::*;
#(
    parameter int CHAR_W = 8
) (
    // Clock, reset and settings
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] enhanced_feature_reg_i,
    input wire logic [7:0] line_control_reg_i,
    input wire logic [7:0] modem_control_reg_i,
    input wire logic [7:0] interrupt_enable_reg_i,
    input wire logic [7:0] second_pause_char_i,
    input wire logic other_sleep_en_i,
    input wire logic other_int_pending_i,
    input wire logic other_rx_idle_i,
    input wire logic other_wake_i,
    // Core side
    input wire logic core_tx_bit_i,
    input wire logic core_tx_busy_i,
    input wire logic [CHAR_W-1:0] rx_char_i,
    input wire logic rx_char_valid_i,
    input wire logic int_pending_i,
    input wire logic thr_write_i,
    input wire logic msr_read_i,
    input wire logic rx_bit_o,
    input wire logic rx_char_ready_o,
    input wire logic special_flag_o,
    input wire logic [3:0] modem_status_reg_o,
    input wire logic auto_rtscts_en_o,
    input wire logic sleep_o,
    // Pins
    input wire logic rx_pin_i,
    input wire logic [3:0] modem_in_i,
    input wire logic tx_pin_o,
    input wire logic rts_pin_o,
    input wire logic dtr_pin_o,
    input wire logic osc_enable_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic loop, ir, hit, calm;
    logic [7:0] mask;
    assign loop = modem_control_reg_i[MCR_LOOP_BIT];
    assign ir = modem_control_reg_i[MCR_IR_BIT];
    assign mask = 8'hff >> (2'h3 - line_control_reg_i[1:0]);
    assign hit = enhanced_feature_reg_i[EFR_SPECIAL_BIT]
        && ((8'(rx_char_i) ^ second_pause_char_i) & mask) == 8'h00;
    // Infrared and loopback kept out: their rx idle level differs
    assign calm = interrupt_enable_reg_i[IER_SLEEP_BIT] && other_sleep_en_i && !int_pending_i
        && !other_int_pending_i && other_rx_idle_i && !other_wake_i && rx_pin_i
        && !thr_write_i && !core_tx_busy_i && !loop && !ir && modem_status_reg_o == 4'h0;
    sequence quiet_s;
        $stable(modem_in_i) && $stable(modem_control_reg_i);
    endsequence
    sequence ready_s;
        calm && $stable(modem_in_i);
    endsequence
    special_match_a:
        assert property (rx_char_valid_i && rx_char_ready_o && hit |=> special_flag_o)
        else $error("special char missed");
    loop_data_a:
        assert property (loop && !ir |=> rx_bit_o == $past(core_tx_bit_i))
        else $error("loop data wrong");
    loop_flow_a:
        assert property (loop |=> !auto_rtscts_en_o) else $error("flow on in loop");
    loop_pins_a:
        assert property (loop [*3] |-> $stable(tx_pin_o)) else $error("tx moved in loop");
    loop_modem_a:
        assert property (loop |=> rts_pin_o && dtr_pin_o) else $error("rts or dtr not held");
    ir_idle_a:
        assert property ((ir && !loop && !core_tx_busy_i) [*3] |-> !tx_pin_o)
        else $error("ir tx not low");
    osc_stop_a:
        assert property (osc_enable_o != sleep_o) else $error("osc and sleep disagree");
    sleep_entry_a:
        assert property (ready_s [*6] |-> sleep_o) else $error("no sleep");
    thr_wake_a:
        assert property (sleep_o && thr_write_i |-> ##[1:2] !sleep_o) else $error("no wake");
    msr_clear_a:
        assert property (quiet_s [*3] ##0 msr_read_i ##1 quiet_s |=> modem_status_reg_o == 4'h0)
        else $error("msr not cleared");
endmodule // uax_aux_checker

bind uax_aux uax_aux_checker #(.CHAR_W(CHAR_W)) u_chk (.*);

// ===== verif/uax_remote.sv
/*
 * Far-side line model: plain UART line or infrared transceiver.
 * Fired by the bench; shares the block clock.
 */
`timescale 1ns/1ps
module uax_remote #(
    parameter int PULSE = 3
) (
    // Control
    input wire logic sys_clk_i,
    input wire logic ir_i,
    input wire logic inv_i,
    input wire logic fire_i,
    // Line
    output logic rx_o
);
    logic [7:0] cnt_q = 8'h00;
    always_ff @(posedge sys_clk_i)
    begin
        if (fire_i)
            cnt_q <= 8'(PULSE);
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
    // Pull-up keeps a plain line marking; dark infrared rests low, or high when inv_i is set
    assign rx_o = !ir_i ? 1'b1 : ((cnt_q != 8'h00) ^ inv_i);
endmodule // uax_remote
